// *** tms_pkg.sv ***
package tms_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    // register addresses
    localparam logic [7:0] ADDR_MASK = 8'h05;
    localparam logic [7:0] ADDR_CTRL_A = 8'h06;
    localparam logic [7:0] ADDR_CTRL_B = 8'h07;
    localparam logic [7:0] ADDR_CMP2_HI = 8'h1d;
    localparam logic [7:0] ADDR_CMP2_LO = 8'h1e;
    localparam logic [7:0] ADDR_STREAM_CMP = 8'h23;
    localparam logic [7:0] ADDR_STATUS = 8'h24;
    localparam logic [7:0] ADDR_STREAM_CTL = 8'h30;
    localparam logic [7:0] ADDR_STATE = 8'h31;
    // field positions
    localparam int MASK_CMP2_BIT = 1;
    localparam int MASK_DOZE_BIT = 4;
    localparam int MASK_DEEP_BIT = 8;
    localparam int CTRLA_TRIG_BIT = 7;
    localparam int CTRLB_DOZE_BIT = 0;
    localparam int CTRLB_CLKO_BIT = 9;
    localparam int CMP2_DIS_BIT = 15;
    localparam int STAT_CMP2_BIT = 2;
    localparam int STAT_DOZE_BIT = 9;
    localparam int STRM_EN_BIT = 0;
    localparam int STRM_RX_BIT = 1;
    localparam int STRM_TX_BIT = 2;
    // reset values
    localparam logic [15:0] MASK_RST = 16'h0000;
    localparam logic [15:0] CTRL_A_RST = 16'h0000;
    localparam logic [15:0] CTRL_B_RST = 16'h0000;
    localparam logic [23:0] CMP2_RST = 24'h000000;
    localparam logic [15:0] STREAM_CMP_RST = 16'h0000;
    localparam logic [2:0] STREAM_CTL_RST = 3'h0;
    // timing
    localparam int CLK_MHZ = 20;
    localparam int WARMUP_US = 144;
    localparam int WAKE_US = 300;
    localparam int WARMUP_CYC = WARMUP_US * CLK_MHZ;
    localparam int WAKE_CYC = WAKE_US * CLK_MHZ;
    localparam int DOZE_ENTRY_TICKS = 128;
    localparam int CNT_W = 13;

    typedef enum logic [2:0] {
        TMS_OFF,
        TMS_IDLE,
        TMS_DOZE_PEND,
        TMS_DOZE,
        TMS_WAKE,
        TMS_WARMUP,
        TMS_ACTIVE
    } tms_state_e;

    typedef struct packed {
        logic stream;
        logic rx;
        logic tx;
        logic [1:0] code;
    } tms_cmd_s;
endpackage : tms_pkg

// *** tms_sequencer.sv ***
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ps
module tms_sequencer
    import tms_pkg::*;
#(
    parameter int WAKE_CYCLES = WAKE_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [DATA_W-1:0] rdata_o,
    input wire logic [23:0] current_time_counter_i,
    input wire logic attention_pin_n_i,
    input wire logic transceiver_enable_pin_i,
    input wire logic clko_tick_i,
    input wire logic clko_slow_i,
    input wire logic op_done_i,
    output logic irq_n_o,
    output logic irq_oe_o,
    output logic timer_run_o,
    output logic clko_enable_o,
    output logic regs_active_o,
    output logic seq_start_o,
    output tms_cmd_s seq_cmd_o,
    output logic op_ready_o,
    output tms_state_e state_o
);
    tms_state_e state_reg;
    tms_state_e state_next;
    logic [15:0] mask_reg;
    logic [15:0] ctrl_a_reg;
    logic [15:0] ctrl_b_reg;
    logic [23:0] cmp2_reg;
    logic cmp2_dis_reg;
    logic cmp2_inhibit_reg;
    logic [15:0] stream_cmp_reg;
    logic [2:0] stream_ctl_reg;
    logic armed_reg;
    logic deep_reg;
    logic stat_cmp2_reg;
    logic stat_doze_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic irq_n_reg;
    logic oe_reg;
    logic start_reg;
    tms_cmd_s cmd_reg;
    logic attention_meta_reg;
    logic attention_sync_reg;
    logic txen_meta_reg;
    logic txen_sync_reg;

    localparam logic [CNT_W-1:0] WARMUP_LAST = CNT_W'(WARMUP_CYC - 1);
    localparam logic [CNT_W-1:0] WAKE_LAST = CNT_W'(WAKE_CYCLES - 1);
    localparam logic [CNT_W-1:0] DOZE_LAST = CNT_W'(DOZE_ENTRY_TICKS - 1);

    // register access is only possible while the serial port is awake
    wire awake = (state_reg == TMS_IDLE) || (state_reg == TMS_WARMUP) ||
                 (state_reg == TMS_ACTIVE);
    wire wr_ok = wr_i && awake;
    wire rd_ok = rd_i && awake;
    wire wr_mask = wr_ok && (addr_i == ADDR_MASK);
    wire wr_ctrl_a = wr_ok && (addr_i == ADDR_CTRL_A);
    wire wr_ctrl_b = wr_ok && (addr_i == ADDR_CTRL_B);
    wire wr_cmp_hi = wr_ok && (addr_i == ADDR_CMP2_HI);
    wire wr_cmp_lo = wr_ok && (addr_i == ADDR_CMP2_LO);
    wire wr_scmp = wr_ok && (addr_i == ADDR_STREAM_CMP);
    wire wr_sctl = wr_ok && (addr_i == ADDR_STREAM_CTL);
    wire rd_status = rd_ok && (addr_i == ADDR_STATUS);

    wire trig_en = ctrl_a_reg[CTRLA_TRIG_BIT];
    wire [1:0] xcvr_seq = ctrl_a_reg[1:0];
    wire stream_mode = stream_ctl_reg[STRM_EN_BIT];
    wire attention_req = !attention_sync_reg;
    wire txen = txen_sync_reg;

    // raw equality used by both the doze wake and the timed trigger
    wire cmp2_equal = (current_time_counter_i == cmp2_reg) && !cmp2_inhibit_reg;
    wire scmp_equal = (current_time_counter_i[15:0] == stream_cmp_reg);
    wire cmp2_hit = cmp2_equal && !cmp2_dis_reg;
    wire scmp_hit = scmp_equal && !cmp2_dis_reg;
    wire sel_hit = stream_mode ? scmp_hit : cmp2_hit;
    wire timed_fire = trig_en && sel_hit;
    wire in_idle = (state_reg == TMS_IDLE);
    wire start_ok = in_idle && armed_reg && txen;
    wire do_start = start_ok && (trig_en ? timed_fire : 1'b1);
    // a timer wake is impossible in deep doze: the timer is frozen
    wire doze_wake = (state_reg == TMS_DOZE) && !deep_reg && cmp2_equal;
    wire doze_abort = attention_req && ((state_reg == TMS_DOZE) ||
                                        (state_reg == TMS_DOZE_PEND));

    assign state_o = state_reg;
    assign rdata_o = rdata_reg;
    assign irq_n_o = irq_n_reg;
    assign irq_oe_o = oe_reg;
    assign seq_start_o = start_reg;
    assign seq_cmd_o = cmd_reg;
    assign op_ready_o = (state_reg == TMS_ACTIVE);
    assign regs_active_o = awake;
    assign timer_run_o = !((state_reg == TMS_DOZE) && deep_reg);
    // slow-clock limit in doze; pending entry keeps it running
    assign clko_enable_o = (state_reg == TMS_DOZE) ?
                           (ctrl_b_reg[CTRLB_CLKO_BIT] && clko_slow_i) :
                           (state_reg != TMS_OFF);

    // state sequencing
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        unique case (state_reg)
            TMS_OFF: begin
                state_next = TMS_IDLE;
            end
            TMS_IDLE: begin
                cnt_next = '0;
                if (do_start) begin
                    state_next = TMS_WARMUP;
                end else if (ctrl_b_reg[CTRLB_DOZE_BIT]) begin
                    state_next = TMS_DOZE_PEND;
                end
            end
            TMS_DOZE_PEND: begin
                if (doze_abort) begin
                    state_next = TMS_IDLE;
                end else if (clko_tick_i) begin
                    cnt_next = cnt_reg + 1'b1;
                    if (cnt_reg == DOZE_LAST) begin
                        state_next = TMS_DOZE;
                        cnt_next = '0;
                    end
                end
            end
            TMS_DOZE: begin
                cnt_next = '0;
                if (doze_wake || doze_abort) begin
                    state_next = TMS_WAKE;
                end
            end
            TMS_WAKE: begin
                // 300 us settle, then wait for the next output clock tick
                if (cnt_reg != WAKE_LAST) begin
                    cnt_next = cnt_reg + 1'b1;
                end else if (clko_tick_i) begin
                    state_next = TMS_IDLE;
                    cnt_next = '0;
                end
            end
            TMS_WARMUP: begin
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg == WARMUP_LAST) begin
                    state_next = TMS_ACTIVE;
                    cnt_next = '0;
                end
            end
            TMS_ACTIVE: begin
                if (op_done_i) begin
                    state_next = TMS_IDLE;
                end
            end
        endcase
    end

    // pins cross into the clock domain through two flops
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            attention_meta_reg <= 1'b1;
            attention_sync_reg <= 1'b1;
            txen_meta_reg <= 1'b0;
            txen_sync_reg <= 1'b0;
        end else begin
            attention_meta_reg <= attention_pin_n_i;
            attention_sync_reg <= attention_meta_reg;
            txen_meta_reg <= transceiver_enable_pin_i;
            txen_sync_reg <= txen_meta_reg;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= TMS_OFF;
            cnt_reg <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mask_reg <= MASK_RST;
            ctrl_a_reg <= CTRL_A_RST;
            stream_cmp_reg <= STREAM_CMP_RST;
            stream_ctl_reg <= STREAM_CTL_RST;
        end else begin
            if (wr_mask) begin
                mask_reg <= wdata_i;
            end
            if (wr_ctrl_a) begin
                ctrl_a_reg <= wdata_i;
            end
            if (wr_scmp) begin
                stream_cmp_reg <= wdata_i;
            end
            if (wr_sctl) begin
                stream_ctl_reg <= wdata_i[2:0];
            end
        end
    end

    // doze enable self-clears on leaving doze, or the block would re-enter it
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_b_reg <= CTRL_B_RST;
        end else if (wr_ctrl_b) begin
            ctrl_b_reg <= wdata_i;
        end else if (state_reg == TMS_WAKE || doze_abort) begin
            ctrl_b_reg[CTRLB_DOZE_BIT] <= 1'b0;
        end
    end

    // the comparator is inhibited from a high-half write until the low half lands
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cmp2_reg <= CMP2_RST;
            cmp2_dis_reg <= 1'b0;
            cmp2_inhibit_reg <= 1'b0;
        end else begin
            if (wr_cmp_hi) begin
                cmp2_reg[23:16] <= wdata_i[7:0];
                cmp2_dis_reg <= wdata_i[CMP2_DIS_BIT];
                cmp2_inhibit_reg <= 1'b1;
            end
            if (wr_cmp_lo) begin
                cmp2_reg[15:0] <= wdata_i;
                cmp2_inhibit_reg <= 1'b0;
            end
        end
    end

    // deep-doze choice is frozen when doze is entered
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            deep_reg <= 1'b0;
        end else if (state_reg == TMS_DOZE_PEND) begin
            deep_reg <= mask_reg[MASK_DEEP_BIT];
        end
    end

    // an operation is armed by writing the selector; start consumes it
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            armed_reg <= 1'b0;
        end else if ((wr_ctrl_a && (wdata_i[1:0] != 2'h0)) ||
                     (wr_sctl && wdata_i[STRM_EN_BIT])) begin
            armed_reg <= 1'b1;
        end else if (do_start) begin
            armed_reg <= 1'b0;
        end
    end

    // status flags: a set in the reading cycle survives the read-clear
    wire set_cmp2 = cmp2_hit || (timed_fire && start_ok);
    wire set_doze = doze_wake;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            stat_cmp2_reg <= 1'b0;
            stat_doze_reg <= 1'b0;
        end else begin
            if (set_cmp2) begin
                stat_cmp2_reg <= 1'b1;
            end else if (rd_status || cmp2_dis_reg) begin
                stat_cmp2_reg <= 1'b0;
            end
            if (set_doze) begin
                stat_doze_reg <= 1'b1;
            end else if (rd_status) begin
                stat_doze_reg <= 1'b0;
            end
        end
    end

    wire irq_any = (stat_cmp2_reg && mask_reg[MASK_CMP2_BIT]) ||
                   (stat_doze_reg && mask_reg[MASK_DOZE_BIT]);
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_n_reg <= 1'b1;
            oe_reg <= 1'b0;
        end else begin
            irq_n_reg <= !irq_any;
            oe_reg <= 1'b1;
        end
    end

    // start pulse and command; packet code read from the sequence field
    wire [15:0] cmp2_hi_view = {cmp2_dis_reg, 7'h00, cmp2_reg[23:16]};
    tms_cmd_s cmd_next;
    assign cmd_next = '{stream: stream_mode,
                        rx: stream_mode && stream_ctl_reg[STRM_RX_BIT],
                        tx: stream_mode && stream_ctl_reg[STRM_TX_BIT],
                        code: stream_mode ? 2'h0 : xcvr_seq};
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            start_reg <= 1'b0;
            cmd_reg <= '0;
        end else begin
            start_reg <= do_start;
            if (do_start) begin
                cmd_reg <= cmd_next;
            end
        end
    end

    // read mux
    logic [DATA_W-1:0] rd_mux;
    always_comb begin
        rd_mux = '0;
        unique case (addr_i)
            ADDR_MASK: rd_mux = mask_reg;
            ADDR_CTRL_A: rd_mux = ctrl_a_reg;
            ADDR_CTRL_B: rd_mux = ctrl_b_reg;
            ADDR_CMP2_HI: rd_mux = cmp2_hi_view;
            ADDR_CMP2_LO: rd_mux = cmp2_reg[15:0];
            ADDR_STREAM_CMP: rd_mux = stream_cmp_reg;
            ADDR_STATUS: begin
                rd_mux[STAT_CMP2_BIT] = stat_cmp2_reg;
                rd_mux[STAT_DOZE_BIT] = stat_doze_reg;
            end
            ADDR_STREAM_CTL: rd_mux = {13'h0000, stream_ctl_reg};
            ADDR_STATE: rd_mux = {12'h000, armed_reg, state_reg};
            default: rd_mux = '0;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_reg <= '0;
        end else if (rd_ok) begin
            rdata_reg <= rd_mux;
        end else begin
            rdata_reg <= '0;
        end
    end
endmodule : tms_sequencer

// *** tms_host_model.sv ***
`timescale 1ns/1ps
module tms_host_model #(
    parameter logic [23:0] TIME_START = 24'h12f000,
    parameter int TICK_DIV = 4,
    parameter int OP_LEN = 20
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic timer_run_i,
    input wire logic op_ready_i,
    output logic [23:0] current_time_counter_o,
    output logic clko_tick_o,
    output logic op_done_o
);
    int div_q;
    int op_q;
    // start high in the range so the upper compare byte is really exercised
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            current_time_counter_o <= TIME_START;
            div_q <= 0;
            op_q <= 0;
        end else begin
            if (timer_run_i) begin
                current_time_counter_o <= current_time_counter_o + 24'h000001;
            end
            div_q <= (div_q == TICK_DIV - 1) ? 0 : div_q + 1;
            op_q <= (op_ready_i && !op_done_o) ? op_q + 1 : 0;
        end
    end
    assign clko_tick_o = (div_q == TICK_DIV - 1);
    assign op_done_o = (op_q == OP_LEN);
endmodule : tms_host_model

// *** tms_sequencer_props.sv ***
`timescale 1ns/1ps
module tms_sequencer_props
    import tms_pkg::*;
#(
    parameter int WAKE_CYCLES = WAKE_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic attention_pin_n_i,
    input wire logic clko_tick_i,
    input wire logic clko_slow_i,
    input wire logic op_done_i,
    input wire logic irq_oe_o,
    input wire logic timer_run_o,
    input wire logic clko_enable_o,
    input wire logic seq_start_o,
    input wire logic op_ready_o,
    input wire tms_state_e state_o
);
    int warm_cnt;
    int tick_cnt;
    int wake_cnt;
    // each counter restarts when its state is left, so every visit is measured alone
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            warm_cnt <= 0;
            tick_cnt <= 0;
            wake_cnt <= 0;
        end else begin
            warm_cnt <= (state_o == TMS_WARMUP) ? warm_cnt + 1 : 0;
            tick_cnt <= (state_o == TMS_DOZE_PEND) ? tick_cnt + int'(clko_tick_i) : 0;
            wake_cnt <= (state_o == TMS_WAKE) ? wake_cnt + 1 : 0;
        end
    end
    default clocking dcb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    AST_RESET_QUIET: assert property (disable iff (1'h0)
        rst_i |-> !irq_oe_o && !seq_start_o && state_o == TMS_OFF) else $error("active in reset");
    AST_START_FROM_IDLE: assert property (seq_start_o |-> $past(state_o) == TMS_IDLE
        && state_o == TMS_WARMUP ##1 !seq_start_o) else $error("start outside idle");
    AST_WARMUP_LEN: assert property (state_o == TMS_ACTIVE && $past(state_o) == TMS_WARMUP
        |-> warm_cnt == WARMUP_CYC) else $error("warmup length wrong");
    AST_DONE_TO_IDLE: assert property (op_ready_o && op_done_i |=> state_o == TMS_IDLE)
        else $error("no idle after done");
    AST_PEND_TICKS: assert property (state_o == TMS_DOZE && $past(state_o) == TMS_DOZE_PEND
        |-> tick_cnt == DOZE_ENTRY_TICKS) else $error("doze entry tick count wrong");
    AST_DOZE_CLKO: assert property (state_o == TMS_DOZE && !clko_slow_i |-> !clko_enable_o)
        else $error("fast clock out in doze");
    AST_TIMER_STOP: assert property (!timer_run_o |-> state_o == TMS_DOZE)
        else $error("timer stopped outside doze");
    AST_ATTENTION_PIN_WAKE: assert property (state_o == TMS_DOZE && !attention_pin_n_i
        |-> ##[1:3] state_o == TMS_WAKE) else $error("attention ignored");
    AST_WAKE_LEN: assert property (state_o == TMS_IDLE && $past(state_o) == TMS_WAKE
        |-> wake_cnt >= WAKE_CYCLES) else $error("wake too short");
endmodule : tms_sequencer_props
bind tms_sequencer tms_sequencer_props #(.WAKE_CYCLES(WAKE_CYCLES)) props_u (
    .clk_i, .rst_i, .attention_pin_n_i, .clko_tick_i, .clko_slow_i, .op_done_i, .irq_oe_o,
    .timer_run_o, .clko_enable_o, .seq_start_o, .op_ready_o, .state_o);

// *** timed_mode_sequencer_bench.sv ***
`timescale 1ns/1ps
module timed_mode_sequencer_bench;
    import tms_pkg::*;
    localparam int WAKE_N = 8;
    localparam int TICK_N = 4;
    logic clk_i = 1'h0, rst_i = 1'h0, wr_i = 1'h0, rd_i = 1'h0, clko_slow_i = 1'h1;
    logic attention_pin_n_i = 1'h1, transceiver_enable_pin_i = 1'h0;
    logic [ADDR_W-1:0] addr_i = 8'h00;
    logic [DATA_W-1:0] wdata_i = 16'h0000;
    logic [DATA_W-1:0] rdata_o;
    logic [23:0] now_w;
    logic tick_w, done_w, irq_n_o, irq_oe_o, timer_run_o, clko_enable_o, seq_start_o, op_ready_o;
    logic regs_active_o;
    tms_cmd_s seq_cmd_o;
    tms_state_e state_o;
    int n_mismatch = 0;
    int n_tests = 0;
    always #25 clk_i = ~clk_i;
    tms_sequencer #(.WAKE_CYCLES(WAKE_N)) dut_u (
        .clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .current_time_counter_i(now_w),
        .attention_pin_n_i, .transceiver_enable_pin_i, .clko_tick_i(tick_w), .clko_slow_i,
        .op_done_i(done_w), .irq_n_o, .irq_oe_o, .timer_run_o, .clko_enable_o, .regs_active_o,
        .seq_start_o, .seq_cmd_o, .op_ready_o, .state_o);
    tms_host_model #(.TICK_DIV(TICK_N)) host_u (
        .clk_i, .rst_i, .timer_run_i(timer_run_o), .op_ready_i(op_ready_o),
        .current_time_counter_o(now_w), .clko_tick_o(tick_w), .op_done_o(done_w));
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test
    task automatic step(input int n);
        repeat (n) begin
            @(posedge clk_i);
            #1;
        end
    endtask : step
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'h1;
        @(posedge clk_i);
        wr_i <= 1'h0;
    endtask : wr_reg
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'h1;
        @(posedge clk_i);
        rd_i <= 1'h0;
        #1;
        check("read data", rdata_o, exp);
    endtask : rd_chk
    task automatic set_txen(input logic v);
        @(posedge clk_i);
        transceiver_enable_pin_i <= v;
    endtask : set_txen
    task automatic wait_state(input tms_state_e s);
        for (int i = 0; i < 4000 && state_o !== s; i++) begin
            step(1);
        end
        check("state", state_o, s);
    endtask : wait_state
    task automatic wait_start;
        for (int i = 0; i < 2000 && seq_start_o !== 1'h1; i++) begin
            step(1);
        end
        check("start pulse", seq_start_o, 1'h1);
    endtask : wait_start
    task automatic t_reset;
        // a real edge on reset, so the asynchronous branch acts before the first clock
        rst_i <= 1'h1;
        step(9);
        check("oe in reset", irq_oe_o, 1'h0);
        check("regs in reset", regs_active_o, 1'h0);
        check("state in reset", state_o, TMS_OFF);
        @(posedge clk_i);
        rst_i <= 1'h0;
        step(2);
        check("state after reset", state_o, TMS_IDLE);
        check("oe after reset", irq_oe_o, 1'h1);
        check("regs after reset", regs_active_o, 1'h1);
        rd_chk(8'hff, 16'h0000);
    endtask : t_reset
    task automatic t_packet;
        logic [23:0] t;
        for (int c = 1; c < 4; c++) begin
            set_txen(1'h0);
            wr_reg(ADDR_MASK, 16'h0002);
            t = now_w + 24'h000190;
            wr_reg(ADDR_CMP2_HI, {8'h00, t[23:16]});
            wr_reg(ADDR_CMP2_LO, t[15:0]);
            wr_reg(ADDR_CTRL_A, {8'h00, 6'h20, c[1:0]});
            set_txen(1'h1);
            wait_start();
            check("start time", now_w, t + 24'h000001);
            check("packet cmd", seq_cmd_o, {3'h0, c[1:0]});
            step(1);
            check("irq on start", irq_n_o, 1'h0);
            wait_state(TMS_ACTIVE);
            wait_state(TMS_IDLE);
            rd_chk(ADDR_STATUS, 16'h0004);
            step(1);
            check("irq cleared", irq_n_o, 1'h1);
        end
    endtask : t_packet
    task automatic t_stream;
        logic [15:0] s;
        set_txen(1'h0);
        wr_reg(ADDR_CTRL_A, 16'h0080);
        wr_reg(ADDR_CMP2_HI, 16'h8000);
        wr_reg(ADDR_CMP2_LO, 16'h0000);
        s = now_w[15:0] + 16'h0040;
        wr_reg(ADDR_STREAM_CMP, s);
        wr_reg(ADDR_STREAM_CTL, 16'h0005);
        set_txen(1'h1);
        step(100);
        check("no start while disabled", state_o, TMS_IDLE);
        // second pass selects rx instead of tx in the stream control
        for (int k = 0; k < 2; k++) begin
            set_txen(1'h0);
            wr_reg(ADDR_CMP2_HI, 16'h0000);
            wr_reg(ADDR_CMP2_LO, 16'h0000);
            s = now_w[15:0] + 16'h0100;
            wr_reg(ADDR_STREAM_CMP, s);
            wr_reg(ADDR_STREAM_CTL, (k == 0) ? 16'h0005 : 16'h0003);
            set_txen(1'h1);
            wait_start();
            check("stream start time", now_w[15:0], s + 16'h0001);
            check("stream cmd", seq_cmd_o, (k == 0) ? 5'h14 : 5'h18);
            wait_state(TMS_IDLE);
        end
        rd_chk(ADDR_STATUS, 16'h0004);
    endtask : t_stream
    task automatic t_doze;
        logic [23:0] t;
        int n;
        set_txen(1'h0);
        wr_reg(ADDR_MASK, 16'h0010);
        t = now_w + 24'h000400;
        wr_reg(ADDR_CMP2_HI, {8'h80, t[23:16]});
        wr_reg(ADDR_CMP2_LO, t[15:0]);
        wr_reg(ADDR_CTRL_B, 16'h0001);
        wait_state(TMS_DOZE);
        check("clko in doze", clko_enable_o, 1'h0);
        check("regs in doze", regs_active_o, 1'h0);
        rd_chk(ADDR_CTRL_B, 16'h0000);
        wait_state(TMS_WAKE);
        check("wake time", now_w, t + 24'h000001);
        step(1);
        check("doze irq", irq_n_o, 1'h0);
        for (n = 1; n < 100 && state_o === TMS_WAKE; n++) begin
            step(1);
        end
        check("wake length", n >= WAKE_N && n <= WAKE_N + TICK_N + 2, 1'h1);
        rd_chk(ADDR_STATUS, 16'h0200);
    endtask : t_doze
    task automatic t_deep;
        wr_reg(ADDR_MASK, 16'h0100);
        wr_reg(ADDR_CMP2_HI, {8'h80, now_w[23:16]});
        wr_reg(ADDR_CMP2_LO, now_w[15:0] + 16'h0258);
        wr_reg(ADDR_CTRL_B, 16'h0201);
        wait_state(TMS_DOZE);
        check("timer stopped", timer_run_o, 1'h0);
        check("clko kept", clko_enable_o, 1'h1);
        @(posedge clk_i);
        clko_slow_i <= 1'h0;
        step(1);
        check("clko too fast", clko_enable_o, 1'h0);
        @(posedge clk_i);
        clko_slow_i <= 1'h1;
        step(150);
        check("still dozing", state_o, TMS_DOZE);
        @(posedge clk_i);
        attention_pin_n_i <= 1'h0;
        wait_state(TMS_IDLE);
        @(posedge clk_i);
        attention_pin_n_i <= 1'h1;
        rd_chk(ADDR_STATUS, 16'h0000);
    endtask : t_deep
    task automatic t_untimed;
        set_txen(1'h0);
        wr_reg(ADDR_STREAM_CTL, 16'h0000);
        wr_reg(ADDR_CTRL_A, 16'h0002);
        step(6);
        check("held by enable pin", state_o, TMS_IDLE);
        set_txen(1'h1);
        wait_start();
        check("untimed cmd", seq_cmd_o, 5'h02);
        wait_state(TMS_IDLE);
    endtask : t_untimed
    initial begin
        t_reset();
        t_packet();
        t_stream();
        t_doze();
        t_deep();
        t_untimed();
        stop_test();
    end
    // roughly twice the expected run length
    initial begin
        repeat (40000) @(posedge clk_i);
        n_mismatch++;
        stop_test();
    end
endmodule : timed_mode_sequencer_bench
